// [design/dual_dac_pkg.sv]
package dual_dac_pkg;

  localparam logic [7:0] CONVERTER0_LOW_BYTE_ADDR = 8'hF9;
  localparam logic [7:0] CONVERTER0_HIGH_BYTE_ADDR = 8'hFA;
  localparam logic [7:0] CONVERTER1_LOW_BYTE_ADDR = 8'hFB;
  localparam logic [7:0] CONVERTER1_HIGH_BYTE_ADDR = 8'hFC;
  localparam logic [7:0] OUTPUT_CONVERTER_CONTROL_ADDR = 8'hFD;

  localparam logic [7:0] CONTROL_RESET = 8'h04;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;

  localparam int EIGHT_BIT_MODE_BIT = 7;
  localparam int CONV1_RANGE_SELECT_BIT = 6;
  localparam int CONV0_RANGE_SELECT_BIT = 5;
  localparam int CONV1_FORCE_ZERO_N_BIT = 4;
  localparam int CONV0_FORCE_ZERO_N_BIT = 3;
  localparam int UPDATE_IMMEDIATE_BIT = 2;
  localparam int CONV1_POWER_ON_BIT = 1;
  localparam int CONV0_POWER_ON_BIT = 0;

  localparam int CODE_WIDTH = 12;
  localparam int HIGH_NIBBLE_WIDTH = 4;

  // special-function register port of the processor core
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic [7:0] wdata;
  } sfr_req_t;

  // what one analog converter is told to do
  typedef struct packed {
    logic power_on;
    logic range_select;
    logic force_zero_n;
    logic [CODE_WIDTH-1:0] code;
  } conv_out_t;

endpackage

// [design/conv_channel.sv]
`timescale 1ns/1ps
module conv_channel
  import dual_dac_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic [7:0] wdata,
  input wire logic eight_bit_mode,
  input wire logic update_immediate,
  input wire logic sync_rise,
  input wire logic force_zero_n,
  input wire logic range_select,
  input wire logic power_on,
  output logic [7:0] low_reg,
  output logic [7:0] high_reg,
  output dual_dac_pkg::conv_out_t out_reg
);
  import dual_dac_pkg::*;

  logic [7:0] low_next;
  logic [7:0] high_next;
  logic [CODE_WIDTH-1:0] held_code_reg;
  logic [CODE_WIDTH-1:0] code_next;
  logic load;

  assign low_next = wr_low ? wdata : low_reg;
  assign high_next = wr_high ? wdata : high_reg;

  // 8-bit codes sit at the top of the 12-bit converter input
  assign code_next = eight_bit_mode ? {low_next, {HIGH_NIBBLE_WIDTH{1'b0}}}
                                    : {high_next[HIGH_NIBBLE_WIDTH-1:0], low_next};

  // only a low-byte write with update_immediate set or the sync rise loads a new code; a lone high write waits
  assign load = (wr_low && update_immediate) || sync_rise;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      low_reg <= DATA_RESET;
      high_reg <= DATA_RESET;
    end else begin
      low_reg <= low_next;
      high_reg <= high_next;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      held_code_reg <= '0;
    end else if (load) begin
      held_code_reg <= code_next;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_reg <= '0;
    end else begin
      out_reg.power_on <= power_on;
      out_reg.range_select <= range_select;
      out_reg.force_zero_n <= force_zero_n;
      if (!force_zero_n) begin
        out_reg.code <= '0;
      end else if (load) begin
        out_reg.code <= code_next;
      end else begin
        out_reg.code <= held_code_reg;
      end
    end
  end
endmodule

// [design/dual_dac_control_regs.sv]
`timescale 1ns/1ps
// Behaviour
// - control bit 7 at 1 runs both converters from the low byte alone (8-bit), at 0 in 12-bit.
// - control bit 6 at 1 gives converter 1 the supply range, at 0 the reference range.
// - control bit 5 at 1 gives converter 0 the supply range, at 0 the reference range.
// - control bit 4 at 0 forces converter 1 to zero whatever its code, at 1 it follows its code.
// - control bit 3 at 0 forces converter 0 to zero whatever its code, at 1 it follows its code.
// - with bit 2 at 1 a converter's output takes its new code as soon as its low byte is written.
// - with bit 2 at 0 data writes are held, and a 0-to-1 change of bit 2 loads both converters together.
// - control bit 1 switches converter 1 on at 1 and off at 0.
// - control bit 0 switches converter 0 on at 1 and off at 0.
// - a 12-bit code is right-justified, low byte bits 7..0 and high byte low nibble bits 11..8.
// - all four data bytes are zero after power-on reset.
module dual_dac_control_regs
  import dual_dac_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input dual_dac_pkg::sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata_reg,
  output logic sfr_hit_reg,
  output dual_dac_pkg::conv_out_t conv0_reg,
  output dual_dac_pkg::conv_out_t conv1_reg
);
  import dual_dac_pkg::*;

  localparam int CONV_COUNT = 2;

  logic [7:0] control_reg;
  logic [7:0] control_next;
  logic sync_rise;
  logic [7:0] low_bytes [CONV_COUNT];
  logic [7:0] high_bytes [CONV_COUNT];
  conv_out_t conv_outs [CONV_COUNT];
  logic [7:0] low_addr [CONV_COUNT];
  logic [7:0] high_addr [CONV_COUNT];
  logic range_bits [CONV_COUNT];
  logic zero_bits [CONV_COUNT];
  logic power_bits [CONV_COUNT];
  logic control_wr;

  assign low_addr[0] = CONVERTER0_LOW_BYTE_ADDR;
  assign low_addr[1] = CONVERTER1_LOW_BYTE_ADDR;
  assign high_addr[0] = CONVERTER0_HIGH_BYTE_ADDR;
  assign high_addr[1] = CONVERTER1_HIGH_BYTE_ADDR;
  assign range_bits[0] = control_reg[CONV0_RANGE_SELECT_BIT];
  assign range_bits[1] = control_reg[CONV1_RANGE_SELECT_BIT];
  assign zero_bits[0] = control_reg[CONV0_FORCE_ZERO_N_BIT];
  assign zero_bits[1] = control_reg[CONV1_FORCE_ZERO_N_BIT];
  assign power_bits[0] = control_reg[CONV0_POWER_ON_BIT];
  assign power_bits[1] = control_reg[CONV1_POWER_ON_BIT];

  assign control_wr = sfr_req.wr && (sfr_req.addr == OUTPUT_CONVERTER_CONTROL_ADDR);
  assign control_next = control_wr ? sfr_req.wdata : control_reg;
  // held codes are released on the write that sets the sync bit
  assign sync_rise = control_wr && !control_reg[UPDATE_IMMEDIATE_BIT]
                     && sfr_req.wdata[UPDATE_IMMEDIATE_BIT];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      control_reg <= CONTROL_RESET;
    end else begin
      control_reg <= control_next;
    end
  end

  // channels act on the control value that takes effect with this write; update_immediate alone uses the stored bit 2
  genvar i;
  generate
    for (i = 0; i < CONV_COUNT; i++) begin : g_conv
      logic range_now;
      logic zero_now;
      logic power_now;
      assign range_now = control_wr ? sfr_req.wdata[i == 0 ? CONV0_RANGE_SELECT_BIT : CONV1_RANGE_SELECT_BIT]
                                    : range_bits[i];
      assign zero_now = control_wr ? sfr_req.wdata[i == 0 ? CONV0_FORCE_ZERO_N_BIT : CONV1_FORCE_ZERO_N_BIT]
                                   : zero_bits[i];
      assign power_now = control_wr ? sfr_req.wdata[i == 0 ? CONV0_POWER_ON_BIT : CONV1_POWER_ON_BIT]
                                    : power_bits[i];
      conv_channel u_chan (
        .mclk(mclk),
        .rst(rst),
        .wr_low(sfr_req.wr && (sfr_req.addr == low_addr[i])),
        .wr_high(sfr_req.wr && (sfr_req.addr == high_addr[i])),
        .wdata(sfr_req.wdata),
        .eight_bit_mode(control_next[EIGHT_BIT_MODE_BIT]),
        .update_immediate(control_reg[UPDATE_IMMEDIATE_BIT]),
        .sync_rise(sync_rise),
        .force_zero_n(zero_now),
        .range_select(range_now),
        .power_on(power_now),
        .low_reg(low_bytes[i]),
        .high_reg(high_bytes[i]),
        .out_reg(conv_outs[i])
      );
    end
  endgenerate

  assign conv0_reg = conv_outs[0];
  assign conv1_reg = conv_outs[1];

  // read data registered from the address presented in the previous cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sfr_rdata_reg <= READ_IDLE;
      sfr_hit_reg <= 1'b0;
    end else begin
      sfr_hit_reg <= 1'b1;
      case (sfr_req.addr)
        CONVERTER0_LOW_BYTE_ADDR: sfr_rdata_reg <= low_bytes[0];
        CONVERTER0_HIGH_BYTE_ADDR: sfr_rdata_reg <= high_bytes[0];
        CONVERTER1_LOW_BYTE_ADDR: sfr_rdata_reg <= low_bytes[1];
        CONVERTER1_HIGH_BYTE_ADDR: sfr_rdata_reg <= high_bytes[1];
        OUTPUT_CONVERTER_CONTROL_ADDR: sfr_rdata_reg <= control_reg;
        default: begin
          sfr_rdata_reg <= READ_IDLE;
          sfr_hit_reg <= 1'b0;
        end
      endcase
    end
  end
endmodule

// [verification/converter_load_model.sv]
`timescale 1ns/1ps
module converter_load_model
  import dual_dac_pkg::*;
(
  input dual_dac_pkg::conv_out_t drive0,
  input dual_dac_pkg::conv_out_t drive1,
  output logic [11:0] level0,
  output logic [11:0] level1
);
  import dual_dac_pkg::*;

  // reference range levels are taken as valid: the core keeps the ADC on while it is used
  // an unpowered output floats and the board pull-down holds it at ground
  assign level0 = (drive0.power_on && drive0.force_zero_n) ? drive0.code : 12'h000;
  assign level1 = (drive1.power_on && drive1.force_zero_n) ? drive1.code : 12'h000;
endmodule

// [verification/dual_dac_chk.sv]
`timescale 1ns/1ps
module dual_dac_chk
  import dual_dac_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input dual_dac_pkg::sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata_reg,
  input wire logic sfr_hit_reg,
  input dual_dac_pkg::conv_out_t conv0_reg,
  input dual_dac_pkg::conv_out_t conv1_reg
);
  import dual_dac_pkg::*;

  logic [7:0] a, d, c;
  logic [3:0] h;
  logic w, m;
  assign {a, w, d} = sfr_req;
  assign m = a inside {[8'hF9:8'hFD]};
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // shadow of the control register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      c <= 8'h04;
    end else if (w && a == 8'hFD) begin
      c <= d;
    end
  end
  // shadow of the converter 0 high nibble
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      h <= 4'h0;
    end else if (w && a == 8'hFA) begin
      h <= d[3:0];
    end
  end
  property p_un; !m |=> !sfr_hit_reg && sfr_rdata_reg == 8'h00; endproperty
  a_un: assert property (p_un) else $error("unmapped read answered");
  property p_hit; m |=> sfr_hit_reg; endproperty
  a_hit: assert property (p_hit) else $error("mapped read missed");
  property p_rd; w && a == 8'hFD ##1 !w && a == 8'hFD |=> sfr_rdata_reg == $past(d, 2); endproperty
  a_rd: assert property (p_rd) else $error("control readback wrong");
  property p_fld; w && a == 8'hFD |=> {conv1_reg.range_select, conv0_reg.range_select, conv1_reg.force_zero_n,
    conv0_reg.force_zero_n, conv1_reg.power_on, conv0_reg.power_on} == {$past(d[6:3]), $past(d[1:0])}; endproperty
  a_fld: assert property (p_fld) else $error("control fields wrong");
  property p_zero; (conv0_reg.force_zero_n || conv0_reg.code == 12'h000)
    && (conv1_reg.force_zero_n || conv1_reg.code == 12'h000); endproperty
  a_zero: assert property (p_zero) else $error("forced output not zero");
  property p_imm; w && a == 8'hF9 && c[2] && c[3]
    |=> conv0_reg.code == (c[7] ? {$past(d), 4'h0} : {$past(h), $past(d)}); endproperty
  a_imm: assert property (p_imm) else $error("low write not applied");
  property p_hold; w && !c[2] && a inside {[8'hF9:8'hFC]} |=> $stable(conv0_reg.code) && $stable(conv1_reg.code);
  endproperty
  a_hold: assert property (p_hold) else $error("held write moved output");
  property p_high; w && c[2] && !c[7] && a inside {8'hFA, 8'hFC} |=> $stable(conv0_reg.code) && $stable(conv1_reg.code);
  endproperty
  a_high: assert property (p_high) else $error("high write moved output");
  c_rise: cover property (w && a == 8'hFD && d[2] && !c[2]);
  c_hold: cover property (w && a == 8'hF9 && !c[2]);
  c_byte: cover property (w && a == 8'hF9 && c[7] && c[2]);
endmodule
bind dual_dac_control_regs dual_dac_chk u_chk (.*);

// [verification/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import dual_dac_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  sfr_req_t sfr_req = '0;
  logic [7:0] sfr_rdata_reg;
  logic sfr_hit_reg;
  conv_out_t conv0_reg, conv1_reg;
  logic [11:0] level0, level1;
  int fails = 0, cmp_count = 0, cycles = 0, ctl = 4;
  int lo[2] = '{0, 0}, hi[2] = '{0, 0}, cd[2] = '{0, 0};
  logic [16:0] plan[$];
  dual_dac_control_regs dut (
    .mclk(mclk),
    .rst(rst),
    .sfr_req(sfr_req),
    .sfr_rdata_reg(sfr_rdata_reg),
    .sfr_hit_reg(sfr_hit_reg),
    .conv0_reg(conv0_reg),
    .conv1_reg(conv1_reg)
  );
  converter_load_model load (.drive0(conv0_reg), .drive1(conv1_reg), .level0(level0), .level1(level1));
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 1000) begin
      fails++;
      conclude();
    end
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(string n, logic [29:0] e, logic [29:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [14:0] ex(int i);
    return {ctl[i], ctl[5 + i], ctl[3 + i], ctl[3 + i] ? cd[i][11:0] : 12'h000};
  endfunction
  function automatic void ld(int i);
    cd[i] = ctl[7] ? lo[i] << 4 : (hi[i] & 15) << 8 | lo[i];
  endfunction
  task automatic op(logic [16:0] p);
    logic [7:0] a, d, e;
    int i;
    logic r;
    a = p[15:8];
    d = p[7:0];
    i = a > 8'hFA;
    r = a == 8'hFD && d[2] && !ctl[2];
    e = a == 8'hFD ? ctl[7:0] : a inside {8'hF9, 8'hFB} ? lo[i][7:0] : a inside {8'hFA, 8'hFC} ? hi[i][7:0] : 8'h00;
    sfr_req = '{addr: a, wr: p[16], wdata: d};
    @(posedge mclk);
    #1;
    if (!p[16]) cmp("read data", e, sfr_rdata_reg);
    if (p[16] && a inside {8'hF9, 8'hFB}) lo[i] = d;
    if (p[16] && a inside {8'hFA, 8'hFC}) hi[i] = d;
    if (p[16] && a == 8'hFD) ctl = d;
    if (p[16] && (r || a inside {8'hF9, 8'hFB} && ctl[2])) begin
      ld(i);
      if (r) ld(1 - i);
    end
    cmp("hit", a inside {[8'hF9:8'hFD]}, sfr_hit_reg);
    cmp("outputs", {ex(0), ex(1)}, {conv0_reg, conv1_reg});
    cmp("levels", {ctl[0] && ctl[3] ? cd[0][11:0] : 12'h0, ctl[1] && ctl[4] ? cd[1][11:0] : 12'h0},
      {level0, level1});
  endtask
  initial begin
    void'($urandom(32'hFC498E35));
    plan = '{17'h1FD1F, 17'h1FA05, 17'h1F934,
      17'h1FD1B, 17'h1FC0A, 17'h1FBBC, 17'h1FD1F,
      17'h1FD9F, 17'h1F9A5, 17'h1FBFF,
      17'h1FD07, 17'h1FD7C, 17'h1FDE3,
      17'h0FD00, 17'h0FA00, 17'h0FC00, 17'h0FB00};
    repeat (8) @(posedge mclk);
    #1;
    rst = 1'b0;
    for (int k = 8'hF8; k < 8'hFF; k++) op({1'b0, k[7:0], 8'h00});
    foreach (plan[k]) op(plan[k]);
    repeat (80) op({1'($urandom), 8'hF8 + 8'($urandom_range(6)), 8'($urandom)});
    // second reset in mid-run: written bytes must return to zero
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    rst = 1'b0;
    ctl = 4;
    lo = '{0, 0};
    hi = '{0, 0};
    cd = '{0, 0};
    for (int k = 8'hF9; k < 8'hFE; k++) op({1'b0, k[7:0], 8'h00});
    conclude();
  end
endmodule
